//--- verilog/baud_div_pkg.sv
// Functional notes
// RULE1: eight-bit divisor, resets to all ones
// RULE2: divisor accessed only as whole byte
// RULE3: divisor k legal 8..255, clock over k
// RULE4: bit rate is base clock over 2k
// RULE5: software disables tx/rx before divisor rewrite
// RULE6: receive sample points timed by divisor counter
// RULE7: sampling keeps two base clock margin
// RULE8: upper accepted rate 22k/(21k+2) times rate
// RULE9: lower accepted rate 20k/(21k-2) times rate
// RULE10: software keeps receive error inside limits
// RULE11: base clock held low while channel disabled
// RULE12: separate eight-bit tx and rx counters
// RULE13: counter reloads after k, toggles serial clock
package baud_div_pkg;

  localparam int          DATA_W        = 32;
  localparam int          DIV_W         = 8;

  // register byte offsets
  localparam logic [11:0] OFS_DIVISOR   = 12'h000;
  localparam logic [11:0] OFS_CONTROL   = 12'h004;
  localparam logic [11:0] OFS_STATUS    = 12'h008;

  // reset value and minimum divisor
  localparam logic [7:0]  DIVISOR_RST   = 8'hff;
  localparam logic [7:0]  DIVISOR_MIN   = 8'h08;

  // control field positions
  localparam int          CTL_CHAN_POS  = 0;
  localparam int          CTL_TX_POS    = 1;
  localparam int          CTL_RX_POS    = 2;

  // status field positions
  localparam int          STS_TXCNT_POS = 0;
  localparam int          STS_RXCNT_POS = 8;
  localparam int          STS_TXCLK_POS = 16;
  localparam int          STS_RXCLK_POS = 17;
  localparam int          STS_ILLEG_POS = 18;
  localparam int          STS_RXRUN_POS = 19;

  // register select codes
  typedef enum logic [1:0] {
    SEL_NONE    = 2'h0,
    SEL_DIVISOR = 2'h1,
    SEL_CONTROL = 2'h2,
    SEL_STATUS  = 2'h3
  } reg_sel_t;

  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_RUN  = 1'b1
  } rx_state_t;

endpackage : baud_div_pkg

//--- verilog/uart_baud_rate_divider.sv
`timescale 1ns/1ps
module uart_baud_rate_divider
  import baud_div_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // base clock from the prescaler, one-cycle pulse per base clock
  input  wire logic              base_tick,
  // receiver start bit detected, one-cycle pulse
  input  wire logic              rx_start,
  // enable bits, gated base clock, serial clocks and bit and sample pulses
  output logic                   channel_enable_bit,
  output logic                   transmit_enable_bit,
  output logic                   receive_enable_bit,
  output logic                   base_tick_gated,
  output logic                   tx_serial_clk,
  output logic                   rx_serial_clk,
  output logic                   tx_bit_tick,
  output logic                   rx_sample
);

  typedef struct packed {
    logic [DIV_W-1:0] divisor_field;
    logic             chan_en;
    logic             tx_en;
    logic             rx_en;
    logic [DIV_W-1:0] tx_cnt;
    logic [DIV_W-1:0] rx_cnt;
    logic             tx_clk;
    logic             rx_clk;
    rx_state_t        rx_state;
    logic             tx_bit;
    logic             rx_smp;
    logic [31:0]      rdata;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == ADDR_W'(OFS_DIVISOR)) begin
      sel = SEL_DIVISOR;
    end else if (addr == ADDR_W'(OFS_CONTROL)) begin
      sel = SEL_CONTROL;
    end else if (addr == ADDR_W'(OFS_STATUS)) begin
      sel = SEL_STATUS;
    end
    return sel;
  endfunction : decode

  logic             setup_ph;
  logic             access_ph;
  reg_sel_t         sel;
  logic             div_illegal;
  logic [DIV_W-1:0] eff_k;
  logic             tx_run;
  logic             rx_run;
  logic             tx_reload;
  logic             rx_reload;
  logic             wr_ok;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign sel       = decode(paddr);

  // values below eight are stored but clamped to eight in use so the counter never races
  assign div_illegal = (state_ff.divisor_field[7:3] == 5'h00);           // RULE3
  assign eff_k       = div_illegal ? DIVISOR_MIN : state_ff.divisor_field; // RULE3

  // no base clock reaches the counters while the channel is off
  assign base_tick_gated = base_tick && state_ff.chan_en;                  // RULE11

  assign tx_run    = state_ff.chan_en && state_ff.tx_en;
  assign rx_run    = state_ff.chan_en && state_ff.rx_en && (state_ff.rx_state == RX_RUN);
  assign tx_reload = base_tick_gated && (state_ff.tx_cnt == eff_k - 8'h01); // RULE13
  assign rx_reload = base_tick_gated && (state_ff.rx_cnt == eff_k - 8'h01); // RULE13

  // divisor takes only whole-byte writes, narrower lane sets are refused
  always_comb begin
    wr_ok = 1'b0;
    unique case (sel)
      SEL_DIVISOR: wr_ok = pstrb[0];                                       // RULE2
      SEL_CONTROL: wr_ok = pstrb[0];
      SEL_STATUS:  wr_ok = 1'b0;
      SEL_NONE:    wr_ok = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = access_ph && ((sel == SEL_NONE) || (pwrite && !wr_ok));

  always_comb begin
    nxt_state        = state_ff;
    nxt_state.tx_bit = 1'b0;
    nxt_state.rx_smp = 1'b0;

    // register writes; enables are expected clear before a divisor rewrite
    if (access_ph && pwrite && wr_ok) begin
      unique case (sel)
        SEL_DIVISOR: nxt_state.divisor_field = pwdata[7:0];                // RULE5
        SEL_CONTROL: begin
          nxt_state.chan_en = pwdata[CTL_CHAN_POS];
          nxt_state.tx_en   = pwdata[CTL_TX_POS];
          nxt_state.rx_en   = pwdata[CTL_RX_POS];
        end
        SEL_STATUS:  nxt_state.chan_en = state_ff.chan_en;
        SEL_NONE:    nxt_state.chan_en = state_ff.chan_en;
      endcase
    end

    // read data captured in setup so the access phase can finish at once
    if (setup_ph) begin
      nxt_state.rdata = 32'h0000_0000;
      unique case (sel)
        SEL_DIVISOR: nxt_state.rdata[7:0] = state_ff.divisor_field;       // RULE1
        SEL_CONTROL: begin
          nxt_state.rdata[CTL_CHAN_POS] = state_ff.chan_en;
          nxt_state.rdata[CTL_TX_POS]   = state_ff.tx_en;
          nxt_state.rdata[CTL_RX_POS]   = state_ff.rx_en;
        end
        SEL_STATUS: begin
          nxt_state.rdata[STS_TXCNT_POS +: DIV_W] = state_ff.tx_cnt;
          nxt_state.rdata[STS_RXCNT_POS +: DIV_W] = state_ff.rx_cnt;
          nxt_state.rdata[STS_TXCLK_POS]          = state_ff.tx_clk;
          nxt_state.rdata[STS_RXCLK_POS]          = state_ff.rx_clk;
          nxt_state.rdata[STS_ILLEG_POS]          = div_illegal;
          nxt_state.rdata[STS_RXRUN_POS]          = (state_ff.rx_state == RX_RUN);
        end
        SEL_NONE:   nxt_state.rdata = 32'h0000_0000;
      endcase
    end

    // transmit divider: full serial period is 2k base clocks
    if (!tx_run) begin
      nxt_state.tx_cnt = 8'h00;
      nxt_state.tx_clk = 1'b0;
    end else if (tx_reload) begin
      nxt_state.tx_cnt = 8'h00;                                            // RULE12
      nxt_state.tx_clk = !state_ff.tx_clk;                                 // RULE13
      nxt_state.tx_bit = state_ff.tx_clk;                                  // RULE4
    end else if (base_tick_gated) begin
      nxt_state.tx_cnt = state_ff.tx_cnt + 8'h01;                          // RULE12
    end

    // receive divider: restarted by each start bit, so the first sample
    // lands k base clocks in, mid-bit, and drift from the far end is
    // tolerated within the accepted rate window on either side
    unique case (state_ff.rx_state)
      RX_IDLE: begin
        nxt_state.rx_cnt = 8'h00;
        nxt_state.rx_clk = 1'b0;
        if (rx_start && state_ff.chan_en && state_ff.rx_en) begin
          nxt_state.rx_state = RX_RUN;                                     // RULE6 RULE8 RULE9
        end
      end
      RX_RUN: begin
        if (!(state_ff.chan_en && state_ff.rx_en)) begin
          nxt_state.rx_state = RX_IDLE;
          nxt_state.rx_cnt   = 8'h00;
          nxt_state.rx_clk   = 1'b0;
        end else if (rx_start) begin
          nxt_state.rx_cnt = 8'h00;                                        // RULE6
          nxt_state.rx_clk = 1'b0;
        end else if (rx_reload) begin
          nxt_state.rx_cnt = 8'h00;                                        // RULE12
          nxt_state.rx_clk = !state_ff.rx_clk;                             // RULE13
          nxt_state.rx_smp = !state_ff.rx_clk;                             // RULE7
        end else if (base_tick_gated) begin
          nxt_state.rx_cnt = state_ff.rx_cnt + 8'h01;                      // RULE12
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff               <= '0;
      state_ff.divisor_field <= DIVISOR_RST;                               // RULE1
      state_ff.rx_state      <= RX_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata              = state_ff.rdata;
  assign channel_enable_bit  = state_ff.chan_en;
  assign transmit_enable_bit = state_ff.tx_en;
  assign receive_enable_bit  = state_ff.rx_en;
  assign tx_serial_clk       = state_ff.tx_clk;
  assign rx_serial_clk       = state_ff.rx_clk;
  assign tx_bit_tick         = state_ff.tx_bit;
  assign rx_sample           = state_ff.rx_smp;

  // checks
  logic [DIV_W-1:0] div_field;
  assign div_field = state_ff.divisor_field;

  sequence s_div_write_full;
    access_ph && pwrite && (sel == SEL_DIVISOR) && pstrb[0];
  endsequence

  sequence s_div_write_part;
    access_ph && pwrite && (sel == SEL_DIVISOR) && !pstrb[0];
  endsequence

  property p_div_reset;
    @(posedge pclk) presetn && !$past(presetn) |-> div_field == DIVISOR_RST;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divisor not ff after reset"); // RULE1

  property p_div_full_write;
    @(posedge pclk) disable iff (!presetn)
      s_div_write_full |=> div_field == $past(pwdata[7:0]);
  endproperty
  a_div_full_write: assert property (p_div_full_write) else $error("divisor write lost"); // RULE2

  property p_div_part_write;
    @(posedge pclk) disable iff (!presetn)
      s_div_write_part |-> pslverr ##1 $stable(div_field);
  endproperty
  a_div_part_write: assert property (p_div_part_write) else $error("partial divisor write"); // RULE2

  property p_k_legal;
    @(posedge pclk) disable iff (!presetn)
      eff_k >= DIVISOR_MIN && (!div_illegal -> eff_k == div_field);
  endproperty
  a_k_legal: assert property (p_k_legal) else $error("divisor below eight used"); // RULE3

  property p_tick_gate;
    @(posedge pclk) disable iff (!presetn)
      !state_ff.chan_en |-> !base_tick_gated ##1 state_ff.tx_cnt == 8'h00;
  endproperty
  a_tick_gate: assert property (p_tick_gate) else $error("base clock not held low"); // RULE11

  property p_tx_toggle;
    @(posedge pclk) disable iff (!presetn)
      tx_reload && tx_run |=> state_ff.tx_clk != $past(state_ff.tx_clk) && state_ff.tx_cnt == 8'h00;
  endproperty
  a_tx_toggle: assert property (p_tx_toggle) else $error("tx counter reload wrong"); // RULE13

  property p_tx_bound;
    @(posedge pclk) disable iff (!presetn)
      state_ff.tx_cnt < eff_k && state_ff.rx_cnt < eff_k;
  endproperty
  a_tx_bound: assert property (p_tx_bound) else $error("counter beyond divisor"); // RULE12

  property p_tx_bit_rate;
    @(posedge pclk) disable iff (!presetn)
      tx_bit_tick |-> $past(state_ff.tx_clk) && !state_ff.tx_clk;
  endproperty
  a_tx_bit_rate: assert property (p_tx_bit_rate) else $error("bit tick not at 2k"); // RULE4

  property p_rx_start;
    @(posedge pclk) disable iff (!presetn)
      rx_start && state_ff.chan_en && state_ff.rx_en ##1 state_ff.chan_en && state_ff.rx_en
        |-> state_ff.rx_cnt == 8'h00 && !state_ff.rx_clk && state_ff.rx_state == RX_RUN;
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("start bit not restarting rx"); // RULE6

  property p_rx_sample;
    @(posedge pclk) disable iff (!presetn)
      rx_sample |-> state_ff.rx_clk && state_ff.rx_cnt == 8'h00 && !$past(state_ff.rx_clk);
  endproperty
  a_rx_sample: assert property (p_rx_sample) else $error("rx sample off counter"); // RULE7

endmodule : uart_baud_rate_divider

//--- tb/uart_baud_rate_divider_tb.sv
`timescale 1ns/1ps
module uart_baud_rate_divider_tb;
  import baud_div_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        base_tick;
  logic        rx_start;
  logic        channel_enable_bit;
  logic        transmit_enable_bit;
  logic        receive_enable_bit;
  logic        base_tick_gated;
  logic        tx_serial_clk;
  logic        rx_serial_clk;
  logic        tx_bit_tick;
  logic        rx_sample;
  int          failures;
  int          comparisons;
  int          tick_div;
  int          tcnt;
  int          f;
  int          n;
  int          h;
  logic [31:0] rd;
  logic        err;
  int          ks[3] = '{8, 9, 255};

  uart_baud_rate_divider #(.ADDR_W(12)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .base_tick, .rx_start,
    .channel_enable_bit, .transmit_enable_bit, .receive_enable_bit, .base_tick_gated,
    .tx_serial_clk, .rx_serial_clk, .tx_bit_tick, .rx_sample);

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'h0; base_tick = 0; rx_start = 0; tick_div = 1; tcnt = 0;
    failures = 0; comparisons = 0;
  end
  always #12.5 pclk = ~pclk;

  // base clock source: one tick every tick_div cycles
  always @(posedge pclk) begin
    tcnt      <= (tcnt + 1 >= tick_div) ? 0 : tcnt + 1;
    base_tick <= (tcnt + 1 >= tick_div);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer; an idle cycle always follows so psel is never assigned twice per step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    check(what, rd, exp);
  endtask : rdc

  // f: cycles to first pulse, n: cycles to the next, h: serial clock high cycles within n
  task automatic gap(input bit rx);
    f = 0; n = 0; h = 0;
    do begin
      @(posedge pclk); #1; f++;
    end while (((rx ? rx_sample : tx_bit_tick) !== 1'b1) && f < 3000);
    do begin
      @(posedge pclk); #1; n++;
      if ((rx ? rx_serial_clk : tx_serial_clk) === 1'b1) h++;
    end while (((rx ? rx_sample : tx_bit_tick) !== 1'b1) && n < 3000);
  endtask : gap

  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    #(25ns * 60000);
    failures++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("divisor reset", OFS_DIVISOR, 32'hff);
    rdc("control reset", OFS_CONTROL, 32'h0);
    check("ready high", {31'h0, pready}, 32'h1);
    $display("test reset done");
    wr(OFS_DIVISOR, 32'h0000aa55);
    rdc("divisor byte", OFS_DIVISOR, 32'h55);
    apb(1'b1, OFS_DIVISOR, 32'h33, 4'he);
    check("partial write err", {31'h0, err}, 32'h1);
    rdc("divisor kept", OFS_DIVISOR, 32'h55);
    rdc("unmapped read", 12'h00c, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b1, OFS_STATUS, 32'h1, 4'hf);
    check("status write err", {31'h0, err}, 32'h1);
    $display("test registers done");
    // channel off: ticks must not reach the divider
    wr(OFS_CONTROL, 32'h2);
    n = 0;
    repeat (40) begin
      @(posedge pclk); #1;
      if (tx_bit_tick === 1'b1 || base_tick_gated !== 1'b0) n++;
    end
    check("gated while off", n, 0);
    check("enable pins off", {29'h0, channel_enable_bit, transmit_enable_bit, receive_enable_bit}, 32'h2);
    $display("test gating done");
    for (int j = 1; j <= 2; j++) begin
      tick_div = j;
      foreach (ks[i]) begin
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_DIVISOR, ks[i]);
        wr(OFS_CONTROL, 32'h3);
        gap(1'b0);
        check("tx bit period", n, 2 * ks[i] * j);
        check("tx clk high", h, ks[i] * j);
        check("gated follows", {31'h0, base_tick_gated}, {31'h0, base_tick});
      end
    end
    $display("test tx rate done");
    tick_div = 1;
    // a divisor of 10 keeps the receive error inside the accepted limits
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_DIVISOR, 32'ha);
    wr(OFS_CONTROL, 32'h7);
    @(posedge pclk);
    rx_start <= 1'b1;
    #1;
    check("enable pins on", {29'h0, channel_enable_bit, transmit_enable_bit, receive_enable_bit}, 32'h7);
    @(posedge pclk);
    rx_start <= 1'b0;
    gap(1'b1);
    check("rx mid bit", {31'h0, f >= 10 && f <= 13}, 32'h1);
    check("rx sample period", n, 20);
    check("rx clk high", h, 10);
    @(posedge pclk);
    rx_start <= 1'b1;
    @(posedge pclk);
    rx_start <= 1'b0;
    gap(1'b1);
    check("rx restart", f, 10);
    gap(1'b0);
    check("tx beside rx", n, 20);
    $display("test rx done");
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_DIVISOR, 32'h3);
    rdc("low divisor kept", OFS_DIVISOR, 32'h3);
    apb(1'b0, OFS_STATUS, 32'h0, 4'h0);
    check("illegal flag", {31'h0, rd[STS_ILLEG_POS]}, 32'h1);
    wr(OFS_CONTROL, 32'h3);
    gap(1'b0);
    check("low divisor as 8", n, 16);
    $display("test low divisor done");
    give_verdict();
  end
endmodule : uart_baud_rate_divider_tb
